// ---- rtl/pvs_source.v ----
// parallel video source: drives syncs, qualifier, pixels, eye select and device reset
// Operation
// (RULE1) device_reset_n held low at least 1.25 us after start.
// (RULE2) vertical sync high for at least one whole line.
// (RULE3) at least two lines of back porch after vertical sync.
// (RULE4) at least one line of front porch before vertical sync.
// (RULE5) porches together at least 6 + 8*max(1, source/display lines).
// (RULE6) horizontal sync high between 4 and 128 pixel clocks.
// (RULE7) at least four pixel clocks from hsync to qualifier rise.
// (RULE8) at least eight pixel clocks from qualifier fall to hsync.
// (RULE9) hsync, qualifier, pixels change away from the rising pixel clock edge.
// (RULE10) eye select changes at least 1 ms before vertical sync edge.
// (RULE11) eye select stable at least 1 ms after vertical sync edge.
// (RULE12) active lines are runs of qualifier high; each counted once.
`timescale 1ns/1ns
`include "pvs_map.vh"
module pvs_source #(
    parameter PCLK_DIV      = 4,
    parameter ACT_PIX       = 64,
    parameter HSW           = 8,
    parameter HBP           = 8,
    parameter HFP           = 12,
    parameter ACT_LINES     = 16,
    parameter DISP_LINES    = 16,
    parameter VSW           = 1,
    parameter VBP           = 8,
    parameter VFP           = 8,
    parameter RST_LOW_CYC   = `PVS_RST_LOW_CYC,
    parameter EYE_GUARD_CYC = `PVS_EYE_GUARD_CYC
) (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        SRST,
    // user control
    input  wire        ENABLE,
    input  wire        STEREO,
    // device pins
    output reg         DEVICE_RESET_N,
    output reg         PIXEL_CLOCK,
    output reg         VSYNC,
    output reg         HSYNC,
    output reg         ACTIVE_PIXEL_QUALIFIER,
    output reg  [23:0] PIXEL_BUS,
    output reg         STEREO_EYE_SELECT,
    // status
    output reg         FRAME_DONE,
    output reg  [15:0] LINE_COUNT
);
    // ------------------------------------------------------------------
    // derived geometry
    // ------------------------------------------------------------------
    function integer max_of;
        input integer a;
        input integer b;
        begin
            max_of = (a > b) ? a : b;
        end
    endfunction
    function integer ceil_div;
        input integer a;
        input integer b;
        begin
            ceil_div = (a + b - 1) / b;
        end
    endfunction
    // clamp the raster values so the geometry never breaks the link timing; RST_LOW_CYC and EYE_GUARD_CYC are used unclamped
    localparam HSW_E  = (HSW < `PVS_HSW_MIN) ? `PVS_HSW_MIN :
                        ((HSW > `PVS_HSW_MAX) ? `PVS_HSW_MAX : HSW);     // [RULE6]
    localparam HBP_E  = max_of(HBP, `PVS_HBP_MIN);                      // [RULE7]
    localparam HFP_E  = max_of(HFP, `PVS_HFP_MIN);                      // [RULE8]
    localparam H_TOT  = HSW_E + HBP_E + ACT_PIX + HFP_E;
    localparam VSW_E  = max_of(VSW, `PVS_VSW_LINES);                    // [RULE2]
    localparam TVB_MN = `PVS_TVB_BASE + `PVS_TVB_MULT *
                        max_of(1, ceil_div(ACT_LINES, DISP_LINES));     // [RULE5]
    localparam VBP_A  = max_of(VBP, `PVS_VBP_LINES);                    // [RULE3]
    localparam VFP_A  = max_of(VFP, `PVS_VFP_LINES);                    // [RULE4]
    localparam VFP_E  = max_of(VFP_A, TVB_MN - VBP_A);                  // [RULE5]
    localparam V_TOT  = VSW_E + VBP_A + ACT_LINES + VFP_E;
    localparam ST_RST = 2'h0;
    localparam ST_RUN = 2'h1;
    // ------------------------------------------------------------------
    // pixel clock
    // ------------------------------------------------------------------
    wire pclk;
    wire adv;
    pvs_pix_div #(.DIV(PCLK_DIV)) u_div (
        .clk  (CORE_CLK),
        .srst (SRST),
        .pclk (pclk),
        .adv  (adv)
    );
    // ------------------------------------------------------------------
    // reset sequencing and raster
    // ------------------------------------------------------------------
    reg [1:0]  state;
    reg [23:0] rst_cnt;
    reg [15:0] hcnt;
    reg [15:0] vcnt;
    reg [23:0] eye_cnt;
    reg        eye_want;
    reg        eye_moved;
    reg        vs_prev;
    wire       h_act = (hcnt >= HSW_E + HBP_E) && (hcnt < HSW_E + HBP_E + ACT_PIX);
    wire       v_act = (vcnt >= VSW_E + VBP_A) && (vcnt < VSW_E + VBP_A + ACT_LINES);
    wire       vs_now = (vcnt < VSW_E);
    wire       last_h = (hcnt == H_TOT - 1);
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            state                  <= ST_RST;
            rst_cnt                <= 24'h000000;
            hcnt                   <= 16'h0000;
            vcnt                   <= 16'h0000;
            vs_prev                <= 1'b0;
            DEVICE_RESET_N         <= 1'b0;
            PIXEL_CLOCK            <= 1'b0;
            VSYNC                  <= 1'b0;
            HSYNC                  <= 1'b0;
            ACTIVE_PIXEL_QUALIFIER <= 1'b0;
            PIXEL_BUS              <= 24'h000000;
            FRAME_DONE             <= 1'b0;
        end else begin
            PIXEL_CLOCK <= pclk;
            FRAME_DONE  <= 1'b0;
            case (state)
                ST_RST: begin
                    // hold device reset for the full low time first
                    if (rst_cnt >= RST_LOW_CYC - 1) begin          // [RULE1]
                        DEVICE_RESET_N <= 1'b1;
                        if (ENABLE)
                            state <= ST_RUN;
                    end else begin
                        rst_cnt <= rst_cnt + 24'h000001;
                    end
                end
                ST_RUN: begin
                    // outputs move on the falling pixel edge, stable at the rise
                    if (adv) begin                                  // [RULE9]
                        HSYNC                  <= (hcnt < HSW_E);   // [RULE6]
                        VSYNC                  <= vs_now;           // [RULE2]
                        ACTIVE_PIXEL_QUALIFIER <= h_act && v_act;   // [RULE12]
                        PIXEL_BUS              <= (h_act && v_act) ?
                                                  {hcnt[7:0], vcnt[7:0], 8'h5a} : 24'h000000;
                        vs_prev                <= vs_now;
                        if (last_h) begin
                            hcnt <= 16'h0000;
                            if (vcnt == V_TOT - 1) begin
                                vcnt       <= 16'h0000;
                                FRAME_DONE <= 1'b1;
                            end else begin
                                vcnt <= vcnt + 16'h0001;
                            end
                        end else begin
                            hcnt <= hcnt + 16'h0001;
                        end
                    end
                end
                default: state <= ST_RST;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    // restart on the first active line, so the total stands past frame end
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            LINE_COUNT <= 16'h0000;
        end else if (state == ST_RUN && adv && last_h && v_act) begin
            if (vcnt == VSW_E + VBP_A)
                LINE_COUNT <= 16'h0001;                             // [RULE12]
            else
                LINE_COUNT <= LINE_COUNT + 16'h0001;                // [RULE12]
        end
    end

    // ------------------------------------------------------------------
    // stereo eye select
    // ------------------------------------------------------------------
    // moves at most once per frame, at the first active line, far from
    // both vsync edges; a frame shorter than twice the guard keeps the eye
    wire eye_go = (state == ST_RUN) && !eye_moved &&
                  (eye_cnt >= EYE_GUARD_CYC) &&
                  (vcnt == VSW_E + VBP_A) &&
                  lines_left_ok(vcnt);                              // [RULE10]
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            eye_cnt           <= 24'h000000;
            eye_want          <= 1'b0;
            eye_moved         <= 1'b0;
            STEREO_EYE_SELECT <= 1'b0;
        end else begin
            // stereo off holds the last eye rather than forcing a change
            eye_want <= STEREO ? ~STEREO_EYE_SELECT : STEREO_EYE_SELECT;
            // hold timer restarts on every vsync edge
            if (state == ST_RUN && adv && (vs_now != vs_prev))
                eye_cnt <= 24'h000000;                              // [RULE11]
            else if (eye_cnt != 24'hffffff)
                eye_cnt <= eye_cnt + 24'h000001;
            if (FRAME_DONE)
                eye_moved <= 1'b0;
            else if (eye_go)
                eye_moved <= 1'b1;
            if (eye_go)
                STEREO_EYE_SELECT <= eye_want;                      // [RULE11]
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // time left before next vsync edge must cover the setup guard
    function lines_left_ok;
        input [15:0] v;
        begin
            lines_left_ok = ((V_TOT - v) * H_TOT * PCLK_DIV) > EYE_GUARD_CYC;
        end
    endfunction
endmodule // pvs_source

// ---- rtl/pvs_map.vh ----
// timing constants for the parallel video source controller
`ifndef PVS_MAP_VH
`define PVS_MAP_VH
`define PVS_CLK_NS          100
`define PVS_RST_LOW_NS      1250
`define PVS_RST_LOW_CYC     ((`PVS_RST_LOW_NS + `PVS_CLK_NS - 1) / `PVS_CLK_NS)
`define PVS_EYE_GUARD_US    1000
`define PVS_EYE_GUARD_CYC   ((`PVS_EYE_GUARD_US * 1000 + `PVS_CLK_NS - 1) / `PVS_CLK_NS)
`define PVS_VSW_LINES       1
`define PVS_VBP_LINES       2
`define PVS_VFP_LINES       1
`define PVS_TVB_BASE        6
`define PVS_TVB_MULT        8
`define PVS_HSW_MIN         4
`define PVS_HSW_MAX         128
`define PVS_HBP_MIN         4
`define PVS_HFP_MIN         8
`endif

// ---- rtl/pvs_pix_div.v ----
// pixel clock divider: makes the link clock and an advance pulse
`timescale 1ns/1ns
module pvs_pix_div #(
    parameter DIV = 4
) (
    input  wire clk,
    input  wire srst,
    output reg  pclk,
    output reg  adv
);
    reg [15:0] cnt;
    always @(posedge clk) begin
        if (srst) begin
            cnt  <= 16'h0000;
            pclk <= 1'b0;
            adv  <= 1'b0;
        end else begin
            adv <= 1'b0;
            if (cnt == DIV[15:0] - 16'h0001) begin
                cnt  <= 16'h0000;
                pclk <= 1'b0;
                // data changes on the falling edge, half a period before the rise
                adv  <= 1'b1;
            end else begin
                cnt <= cnt + 16'h0001;
                if (cnt == (DIV[15:0] >> 1) - 16'h0001)
                    pclk <= 1'b1;
            end
        end
    end
endmodule // pvs_pix_div

// ---- verification/pvs_source_asserts.sv ----
// checker: device pin timing of the video source
`timescale 1ns/1ns
module pvs_source_asserts #(
    parameter PCLK_DIV      = 4,
    parameter RST_LOW_CYC   = 13,
    parameter EYE_GUARD_CYC = 20
) (
    // clock and control
    input wire        CORE_CLK, SRST, ENABLE, STEREO,
    // device pins and status
    input wire        DEVICE_RESET_N, PIXEL_CLOCK, VSYNC, HSYNC, ACTIVE_PIXEL_QUALIFIER,
    input wire [23:0] PIXEL_BUS,
    input wire        STEREO_EYE_SELECT, FRAME_DONE,
    input wire [15:0] LINE_COUNT
);
    wire       q = ACTIVE_PIXEL_QUALIFIER;
    reg [15:0] rst_lo, hs_age, q_age, eye_age, vs_age;
    reg [7:0]  hs_vs, hs_q;
    // ages saturate so a long idle never wraps into a short gap
    always @(posedge CORE_CLK) begin
        rst_lo  <= (SRST | DEVICE_RESET_N) ? 16'h0 : rst_lo + 16'h1;
        hs_age  <= $rose(HSYNC) ? 16'h1 : hs_age + {15'h0, ~&hs_age};
        q_age   <= SRST ? 16'hffff : $fell(q) ? 16'h1 : q_age + {15'h0, ~&q_age};
        eye_age <= SRST ? 16'hffff : $changed(STEREO_EYE_SELECT) ? 16'h1 :
                   eye_age + {15'h0, ~&eye_age};
        vs_age  <= SRST ? 16'hffff : $changed(VSYNC) ? 16'h1 : vs_age + {15'h0, ~&vs_age};
        hs_vs   <= (SRST | $rose(VSYNC)) ? 8'h0 : hs_vs + {7'h0, $rose(HSYNC) & ~&hs_vs};
        hs_q    <= SRST ? 8'hff : $fell(q) ? 8'h0 : hs_q + {7'h0, $rose(HSYNC) & ~&hs_q};
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    sequence s_hs_start;
        $rose(HSYNC);
    endsequence
    chk_reset_width: assert property ($rose(DEVICE_RESET_N) |-> rst_lo >= RST_LOW_CYC)
        else $error("device reset too short");
    chk_vsync_width: assert property ($fell(VSYNC) |-> (vs_age >= 16 * PCLK_DIV) ##0 s_hs_start)
        else $error("vsync shorter than a line");
    chk_vert_back: assert property ($rose(q) |-> hs_vs >= 8'h2)
        else $error("vertical back porch short");
    chk_vert_front: assert property ($rose(VSYNC) |-> hs_q >= 8'h1)
        else $error("vertical front porch short");
    // first active line of a frame: 14 blank lines plus its own sync
    chk_blank_total: assert property ($rose(q) && hs_q > 8'h1 |-> hs_q >= 8'h0f)
        else $error("vertical blanking short");
    chk_hsync_width: assert property ($fell(HSYNC) |->
        hs_age >= 4 * PCLK_DIV && hs_age <= 128 * PCLK_DIV)
        else $error("hsync width out of range");
    chk_horiz_back: assert property ($rose(q) |-> hs_age >= 4 * PCLK_DIV)
        else $error("horizontal back porch short");
    chk_horiz_front: assert property (s_hs_start |-> q_age >= 8 * PCLK_DIV)
        else $error("horizontal front porch short");
    chk_pin_align: assert property ($changed({HSYNC, q, PIXEL_BUS}) |-> !$rose(PIXEL_CLOCK))
        else $error("pins change on sampling edge");
    chk_eye_setup: assert property ($changed(VSYNC) |-> eye_age >= EYE_GUARD_CYC)
        else $error("eye select setup short");
    chk_eye_hold: assert property ($changed(STEREO_EYE_SELECT) |-> vs_age >= EYE_GUARD_CYC)
        else $error("eye select hold short");
endmodule // pvs_source_asserts

// ---- verification/pvs_sink.sv ----
// model: receiving display device sampling the video pins
`timescale 1ns/1ns
module pvs_sink (
    // core clock and device pins
    input wire        clk, reset_n, pclk, vsync, qual,
    input wire [23:0] pix,
    // what the device saw
    output reg [15:0] lines, pix_cnt,
    output reg [7:0]  last_low
);
    reg        pclk_d, q_d, vs_d;
    reg [15:0] run, npix;
    always @(posedge clk) begin
        pclk_d <= pclk;
        if (!reset_n) begin
            {q_d, vs_d, lines, run, npix, pix_cnt, last_low} <= 0;
        end else if (pclk & ~pclk_d) begin
            q_d  <= qual;
            vs_d <= vsync;
            npix <= qual ? npix + 16'h1 : 16'h0;
            if (qual) last_low <= pix[7:0];
            if (q_d & ~qual) pix_cnt <= npix;
            if (vsync & ~vs_d) lines <= run;
            run <= (vsync & ~vs_d) ? 16'h0 : run + {15'h0, qual & ~q_d};
        end
    end
endmodule // pvs_sink

// ---- verification/pvs_source_bench.sv ----
// bench: video source driving a model of the receiving device
`timescale 1ns/1ns
module pvs_source_bench;
    reg         CORE_CLK, SRST, ENABLE, STEREO, eye_prev;
    wire        DEVICE_RESET_N, PIXEL_CLOCK, VSYNC, HSYNC, ACTIVE_PIXEL_QUALIFIER;
    wire        STEREO_EYE_SELECT, FRAME_DONE;
    wire [23:0] PIXEL_BUS;
    wire [15:0] LINE_COUNT, lines, pix_cnt;
    wire [7:0]  last_low;
    reg  [1:0]  rows [0:3];
    integer     errors, checks, i, n;
    pvs_source #(.ACT_PIX(8), .HSW(4), .HBP(4), .ACT_LINES(4),
        .EYE_GUARD_CYC(20)) u_pvs_source (.CORE_CLK(CORE_CLK), .SRST(SRST),
        .ENABLE(ENABLE), .STEREO(STEREO), .DEVICE_RESET_N(DEVICE_RESET_N), .PIXEL_CLOCK(PIXEL_CLOCK),
        .VSYNC(VSYNC), .HSYNC(HSYNC), .ACTIVE_PIXEL_QUALIFIER(ACTIVE_PIXEL_QUALIFIER),
        .PIXEL_BUS(PIXEL_BUS), .STEREO_EYE_SELECT(STEREO_EYE_SELECT), .FRAME_DONE(FRAME_DONE),
        .LINE_COUNT(LINE_COUNT));
    pvs_sink u_pvs_sink (.clk(CORE_CLK), .reset_n(DEVICE_RESET_N), .pclk(PIXEL_CLOCK),
        .vsync(VSYNC), .qual(ACTIVE_PIXEL_QUALIFIER), .pix(PIXEL_BUS), .lines(lines),
        .pix_cnt(pix_cnt), .last_low(last_low));
    task chk(input string name, input [23:0] exp, input [23:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // pulse stands one cycle, so step past the edge before looking
    task wait_done;
        begin
            n = 0;
            @(posedge CORE_CLK); #1;
            while (FRAME_DONE !== 1'b1 && n < 4000) begin @(posedge CORE_CLK); #1; n = n + 1; end
            chk("frame_done", 24'h1, {23'h0, n < 4000});
        end
    endtask
    task do_reset;
        begin
            @(negedge CORE_CLK); SRST = 1;
            repeat (2) @(negedge CORE_CLK);
            chk("reset_pins", 24'h0, {DEVICE_RESET_N, HSYNC, VSYNC, ACTIVE_PIXEL_QUALIFIER});
            SRST = 0;
            n = 0;
            while (DEVICE_RESET_N !== 1'b1 && n < 40) begin @(negedge CORE_CLK); n = n + 1; end
            chk("reset_low", 24'h1, {23'h0, n >= 13 && n <= 14});
        end
    endtask
    initial begin
        CORE_CLK = 0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end
    initial begin
        repeat (30000) @(posedge CORE_CLK);
        errors = errors + 1;
        results;
    end
    initial begin
        errors = 0; checks = 0; SRST = 1; ENABLE = 0; STEREO = 0;
        rows[0] = 2'b00; rows[1] = 2'b11; rows[2] = 2'b11; rows[3] = 2'b01;
        do_reset;
        repeat (40) @(negedge CORE_CLK);
        chk("idle_raster", 24'h0, {HSYNC, VSYNC});
        ENABLE = 1;
        eye_prev = STEREO_EYE_SELECT;
        // rows: {stereo for the frame, device saw a full earlier frame}
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge CORE_CLK); STEREO = rows[i][1];
            if (i == 1) ENABLE = 0;
            wait_done;
            chk("line_count", 24'h4, {8'h0, LINE_COUNT});
            chk("dev_lines", rows[i][0] ? 24'h4 : 24'h0, {8'h0, lines});
            chk("dev_pixels", 24'h8, {8'h0, pix_cnt});
            chk("pix_low", 24'h5a, {16'h0, last_low});
            chk("eye_flip", {23'h0, rows[i][1]}, {23'h0, STEREO_EYE_SELECT ^ eye_prev});
            eye_prev = STEREO_EYE_SELECT;
        end
        repeat (300) @(negedge CORE_CLK);
        do_reset;
        repeat (60) @(negedge CORE_CLK);
        chk("stopped", 24'h0, {HSYNC, VSYNC, PIXEL_BUS});
        results;
    end
endmodule // pvs_source_bench
bind pvs_source pvs_source_asserts #(.PCLK_DIV(PCLK_DIV), .RST_LOW_CYC(RST_LOW_CYC),
    .EYE_GUARD_CYC(EYE_GUARD_CYC)) u_pvs_source_asserts (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .ENABLE(ENABLE), .STEREO(STEREO), .DEVICE_RESET_N(DEVICE_RESET_N), .PIXEL_CLOCK(PIXEL_CLOCK),
    .VSYNC(VSYNC), .HSYNC(HSYNC), .ACTIVE_PIXEL_QUALIFIER(ACTIVE_PIXEL_QUALIFIER),
    .PIXEL_BUS(PIXEL_BUS), .STEREO_EYE_SELECT(STEREO_EYE_SELECT), .FRAME_DONE(FRAME_DONE),
    .LINE_COUNT(LINE_COUNT));
